//--- design/urq_rx_queue.sv
`timescale 1ns/1ns
`default_nettype none
module urq_rx_queue
    import urq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Configuration, apply strobe restarts queue, threshold count, fault counters and silence timer
    input wire urq_cfg_t cfg,
    input wire logic cfg_apply,
    // Received characters from the line receiver
    input wire urq_rx_char_t rx_char,
    input wire logic rx_char_valid,
    // Transmit state
    input wire logic tx_busy,
    input wire logic tx_done,
    // Parity generation for the transmit side
    input wire logic [7:0] tx_byte,
    output logic tx_parity_bit,
    // Modem lines
    input wire logic carrier_detect,
    input wire logic clear_to_send,
    // Queue read side
    input wire logic rd_en,
    output urq_entry_t rd_entry,
    output logic rd_valid,
    // Events and status
    output logic rx_irq,
    output logic carrier_event,
    output logic cts_event,
    output urq_status_t status
);
    urq_entry_t queue_mem [QUEUE_DEPTH];
    logic [QUEUE_AW-1:0] wr_ptr_reg;
    logic [QUEUE_AW-1:0] rd_ptr_reg;
    logic [QUEUE_AW:0] fill_reg;
    logic [THR_W-1:0] thr_cnt_reg;
    logic [11:0] tick_div_reg;
    logic tick;
    logic [STAMP_W-1:0] stamp_reg;
    logic dcd_reg;
    logic cts_reg;
    logic accept;
    logic par_err;
    logic do_read;
    logic [3:0] err_code;
    logic [CNT_W-1:0] frame_cnt_reg;
    logic [CNT_W-1:0] parity_cnt_reg;
    logic [CNT_W-1:0] break_cnt_reg;
    logic [CNT_W-1:0] fifo_cnt_reg;
    logic [CNT_W-1:0] qovr_cnt_reg;
    logic [CNT_W-1:0] any_err_sum;

    // Expected parity bit for a byte under the chosen scheme
    function automatic logic parity_of(input logic [7:0] b, input urq_parity_t p);
        logic r;
        r = 1'b0;
        unique case (p)
            URQ_PAR_ODD: r = ~(^b);
            URQ_PAR_EVEN: r = ^b;
            URQ_PAR_MARK: r = 1'b1;
            URQ_PAR_SPACE: r = 1'b0;
            default: r = 1'b0; // None, and illegal codes
        endcase
        return r;
    endfunction : parity_of

    // Wrapping counter step; 16-bit rollover is natural
    function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c, input logic hit);
        return hit ? c + CNT_ONE : c;
    endfunction : bump

    // Same rule drives generation and checking
    assign tx_parity_bit = parity_of(tx_byte, cfg.parity);
    assign par_err = (cfg.parity != URQ_PAR_NONE) &&
                     (rx_char.parity_bit != parity_of(rx_char.data, cfg.parity));
    // Half-duplex discard
    assign accept = rx_char_valid && !(cfg.discard_rx_on_tx && tx_busy);
    // Reads are ignored when nothing waits or a config restart is in flight
    assign do_read = rd_en && (fill_reg != '0) && !cfg_apply;
    assign err_code = {rx_char.fifo_overrun, rx_char.break_det, par_err, rx_char.frame_err};
    assign rd_valid = (fill_reg != '0);
    assign tick = (tick_div_reg == TICK_LAST);

    // Fixed timestamp tick divider
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            tick_div_reg <= '0;
        else if (tick)
            tick_div_reg <= '0;
        else
            tick_div_reg <= tick_div_reg + 12'h001;
    end

    // Silence timer saturates so a long idle never looks short
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            stamp_reg <= '0;
        else if (cfg_apply || tx_done || accept)
            stamp_reg <= '0;
        else if (tick && stamp_reg != STAMP_MAX)
            stamp_reg <= stamp_reg + 16'h0001;
    end

    // Queue storage; plain mode strips error and time
    always_ff @(posedge core_clk)
    begin
        if (accept && !cfg_apply)
        begin
            queue_mem[wr_ptr_reg].data <= rx_char.data;
            queue_mem[wr_ptr_reg].err_code <= cfg.annotated_mode ? err_code : 4'h0;
            queue_mem[wr_ptr_reg].stamp <= cfg.annotated_mode ? stamp_reg : 16'h0000;
        end
    end

    // Registered read data
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            rd_entry <= '0;
        else
            rd_entry <= queue_mem[rd_ptr_reg];
    end

    // Pointers and fill; overflow overwrites oldest entry
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg <= '0;
        end
        else if (cfg_apply)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg <= '0;
        end
        else
        begin
            if (accept)
                wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
            if ((accept && fill_reg == FILL_FULL) || do_read)
                rd_ptr_reg <= rd_ptr_reg + PTR_ONE;
            if (accept && !do_read && fill_reg != FILL_FULL)
                fill_reg <= fill_reg + FILL_ONE;
            else if (do_read && !accept)
                fill_reg <= fill_reg - FILL_ONE;
        end
    end

    // Threshold interrupt, one pulse per threshold bytes
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            thr_cnt_reg <= '0;
            rx_irq <= 1'b0;
        end
        else if (cfg_apply)
        begin
            thr_cnt_reg <= '0;
            rx_irq <= 1'b0;
        end
        else
        begin
            rx_irq <= 1'b0;
            if (accept)
            begin
                // A threshold of zero is treated as one
                if (thr_cnt_reg + THR_ONE >= cfg.rx_threshold)
                begin
                    thr_cnt_reg <= '0;
                    rx_irq <= 1'b1;
                end
                else
                    thr_cnt_reg <= thr_cnt_reg + THR_ONE;
            end
        end
    end

    // Modem line change events; inputs are already synchronous
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dcd_reg <= 1'b0;
            cts_reg <= 1'b0;
            carrier_event <= 1'b0;
            cts_event <= 1'b0;
        end
        else
        begin
            dcd_reg <= carrier_detect;
            cts_reg <= clear_to_send;
            carrier_event <= cfg.carrier_change_event_en && (carrier_detect != dcd_reg);
            cts_event <= cfg.cts_change_event_en && (clear_to_send != cts_reg);
        end
    end

    // Framing faults since configuration
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            frame_cnt_reg <= CNT_ZERO;
        else if (cfg_apply)
            frame_cnt_reg <= CNT_ZERO;
        else if (accept)
            frame_cnt_reg <= bump(frame_cnt_reg, rx_char.frame_err);
    end

    // Parity faults since configuration
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            parity_cnt_reg <= CNT_ZERO;
        else if (cfg_apply)
            parity_cnt_reg <= CNT_ZERO;
        else if (accept)
            parity_cnt_reg <= bump(parity_cnt_reg, par_err);
    end

    // Break conditions since configuration
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            break_cnt_reg <= CNT_ZERO;
        else if (cfg_apply)
            break_cnt_reg <= CNT_ZERO;
        else if (accept)
            break_cnt_reg <= bump(break_cnt_reg, rx_char.break_det);
    end

    // Line receiver FIFO overruns since configuration
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            fifo_cnt_reg <= CNT_ZERO;
        else if (cfg_apply)
            fifo_cnt_reg <= CNT_ZERO;
        else if (accept)
            fifo_cnt_reg <= bump(fifo_cnt_reg, rx_char.fifo_overrun);
    end

    // Queue overruns; a read in the same cycle frees a slot, so nothing is lost
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            qovr_cnt_reg <= CNT_ZERO;
        else if (cfg_apply)
            qovr_cnt_reg <= CNT_ZERO;
        else if (accept)
            qovr_cnt_reg <= bump(qovr_cnt_reg, fill_reg == FILL_FULL && !do_read);
    end

    // Aggregate is derived, wraps the same way as the parts
    assign any_err_sum = frame_cnt_reg + parity_cnt_reg + break_cnt_reg + fifo_cnt_reg + qovr_cnt_reg;

    // Status word gathered from its own registers, one driver only
    assign status = '{
        frame_fault_count: frame_cnt_reg,
        parity_fault_count: parity_cnt_reg,
        break_count: break_cnt_reg,
        fifo_overrun_count: fifo_cnt_reg,
        queue_overrun_count: qovr_cnt_reg,
        any_error_count: any_err_sum,
        queue_fill_level: fill_reg
    };
endmodule : urq_rx_queue
`default_nettype wire

//--- include/urq_pkg.sv
`default_nettype none
package urq_pkg;
    localparam int unsigned QUEUE_DEPTH = 1024;
    localparam int unsigned QUEUE_AW = 10;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned STAMP_W = 16;
    localparam int unsigned THR_W = 10;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned TICK_US = 100;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
    localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [STAMP_W-1:0] STAMP_MAX = 16'hffff;
    localparam logic [QUEUE_AW:0] FILL_FULL = 11'h400;
    localparam logic [QUEUE_AW:0] FILL_ONE = 11'h001;
    localparam logic [QUEUE_AW-1:0] PTR_ONE = 10'h001;
    localparam logic [THR_W-1:0] THR_ONE = 10'h001;
    localparam logic [19:0] CNT_SUM_PAD = 20'h00000;

    typedef enum logic [2:0] {
        URQ_PAR_NONE = 3'h0,
        URQ_PAR_ODD = 3'h1,
        URQ_PAR_EVEN = 3'h2,
        URQ_PAR_MARK = 3'h3,
        URQ_PAR_SPACE = 3'h4
    } urq_parity_t;

    // Error code bit positions
    localparam int unsigned ERR_FRAME = 0;
    localparam int unsigned ERR_PARITY = 1;
    localparam int unsigned ERR_BREAK = 2;
    localparam int unsigned ERR_FIFO = 3;

    typedef struct packed {
        logic [THR_W-1:0] rx_threshold;
        urq_parity_t parity;
        logic annotated_mode;
        logic discard_rx_on_tx;
        logic carrier_change_event_en;
        logic cts_change_event_en;
    } urq_cfg_t;

    // Character from the line receiver with its detected faults
    typedef struct packed {
        logic [7:0] data;
        logic parity_bit;
        logic frame_err;
        logic break_det;
        logic fifo_overrun;
    } urq_rx_char_t;

    typedef struct packed {
        logic [7:0] data;
        logic [3:0] err_code;
        logic [STAMP_W-1:0] stamp;
    } urq_entry_t;

    typedef struct packed {
        logic [CNT_W-1:0] frame_fault_count;
        logic [CNT_W-1:0] parity_fault_count;
        logic [CNT_W-1:0] break_count;
        logic [CNT_W-1:0] fifo_overrun_count;
        logic [CNT_W-1:0] queue_overrun_count;
        logic [CNT_W-1:0] any_error_count;
        logic [QUEUE_AW:0] queue_fill_level;
    } urq_status_t;
endpackage : urq_pkg
`default_nettype wire

//--- verification/urq_rx_queue_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module urq_rx_queue_monitor
    import urq_pkg::*;
(
    // Clock, reset and inputs
    input wire logic core_clk,
    input wire logic reset_n,
    input wire urq_cfg_t cfg,
    input wire logic cfg_apply,
    input wire urq_rx_char_t rx_char,
    input wire logic rx_char_valid,
    input wire logic tx_busy,
    input wire logic [7:0] tx_byte,
    input wire logic carrier_detect,
    input wire logic clear_to_send,
    input wire logic rd_en,
    // Outputs
    input wire logic tx_parity_bit,
    input wire logic rx_irq,
    input wire logic carrier_event,
    input wire logic cts_event,
    input wire urq_status_t status
);
    // Character accepted this cycle
    wire logic taken = rx_char_valid && !(cfg.discard_rx_on_tx && tx_busy) && !cfg_apply;
    wire logic [10:0] fill = status.queue_fill_level;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    AST_PUSH: assert property (taken && !rd_en && fill != FILL_FULL |=> fill == $past(fill) + FILL_ONE)
        else $error("fill did not grow");
    AST_DROP: assert property (rx_char_valid && cfg.discard_rx_on_tx && tx_busy && !rd_en && !cfg_apply
        |=> $stable(status) && !rx_irq)
        else $error("byte kept while sending");
    AST_CFG: assert property (cfg_apply |=> status == '0)
        else $error("status not cleared");
    AST_FRAME: assert property (taken && rx_char.frame_err
        |=> status.frame_fault_count == $past(status.frame_fault_count) + CNT_ONE)
        else $error("frame count wrong");
    AST_SUM: assert property (status.any_error_count == status.frame_fault_count + status.parity_fault_count
        + status.break_count + status.fifo_overrun_count + status.queue_overrun_count)
        else $error("sum wrong");
    AST_PAR: assert property (cfg.parity != URQ_PAR_NONE |-> tx_parity_bit == (cfg.parity == URQ_PAR_ODD ?
        ~^tx_byte : cfg.parity == URQ_PAR_EVEN ? ^tx_byte : cfg.parity == URQ_PAR_MARK))
        else $error("parity bit wrong");
    AST_IRQ: assert property (rx_irq |-> $past(taken))
        else $error("irq without byte");
    AST_CAR: assert property (cfg.carrier_change_event_en && $changed(carrier_detect) |=> carrier_event)
        else $error("carrier event missing");
    AST_CTS: assert property (cfg.cts_change_event_en && $changed(clear_to_send) |=> cts_event)
        else $error("cts event missing");
    AST_FULL: assert property (taken && !rd_en && fill == FILL_FULL |=> fill == FILL_FULL
        && status.queue_overrun_count == $past(status.queue_overrun_count) + CNT_ONE)
        else $error("overrun not counted");
    cover property (rx_irq);
    cover property (carrier_event);
    cover property (taken && fill == FILL_FULL);
endmodule : urq_rx_queue_monitor
bind urq_rx_queue urq_rx_queue_monitor urq_rx_queue_monitor_inst (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cfg(cfg),
    .cfg_apply(cfg_apply),
    .rx_char(rx_char),
    .rx_char_valid(rx_char_valid),
    .tx_busy(tx_busy),
    .tx_byte(tx_byte),
    .carrier_detect(carrier_detect),
    .clear_to_send(clear_to_send),
    .rd_en(rd_en),
    .tx_parity_bit(tx_parity_bit),
    .rx_irq(rx_irq),
    .carrier_event(carrier_event),
    .cts_event(cts_event),
    .status(status)
);
`default_nettype wire

//--- verification/urq_remote_dev.sv
`timescale 1ns/1ns
`default_nettype none
module urq_remote_dev
    import urq_pkg::*;
(
    // Clock and send request
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic send,
    input wire logic [7:0] byte_in,
    input wire logic [3:0] fault,
    input wire urq_parity_t parity,
    // Character towards the receiver
    output urq_rx_char_t rx_char,
    output logic rx_char_valid
);
    logic pbit;
    // Parity as the remote end sends it
    always_comb
    begin
        case (parity)
            URQ_PAR_ODD: pbit = ~^byte_in;
            URQ_PAR_EVEN: pbit = ^byte_in;
            URQ_PAR_MARK: pbit = 1'b1;
            default: pbit = 1'b0;
        endcase
    end
    // Idle cycles show inverted junk so a stale byte never looks valid
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            rx_char <= '0;
        else if (send)
            rx_char <= {byte_in, pbit ^ fault[1], fault[0], fault[2], fault[3]};
        else
            rx_char <= ~rx_char;
    end
    // One valid pulse per requested cycle
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            rx_char_valid <= 1'b0;
        else
            rx_char_valid <= send;
    end
endmodule : urq_remote_dev
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
    import urq_pkg::*;
;
    typedef struct packed {urq_parity_t p; logic [7:0] b; logic e;} urq_row_t;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    urq_cfg_t cfg = '0;
    logic cfg_apply = 1'b0, tx_busy = 1'b0, tx_done = 1'b0, rd_en = 1'b0, send = 1'b0;
    logic carrier_detect = 1'b0, clear_to_send = 1'b0;
    logic [7:0] tx_byte = '0, byte_in = '0;
    logic [3:0] fault = '0;
    logic tx_parity_bit, rd_valid, rx_irq, carrier_event, cts_event, rx_char_valid;
    urq_rx_char_t rx_char;
    urq_entry_t rd_entry;
    urq_status_t status;
    int fail_count = 0, cmp_count = 0, irq_n = 0, ev_n = 0;
    urq_row_t rows [6] = '{'{URQ_PAR_ODD, 8'h00, 1'b1}, '{URQ_PAR_ODD, 8'h07, 1'b0},
        '{URQ_PAR_EVEN, 8'h01, 1'b1}, '{URQ_PAR_EVEN, 8'h81, 1'b0},
        '{URQ_PAR_MARK, 8'h00, 1'b1}, '{URQ_PAR_SPACE, 8'hff, 1'b0}};
    urq_rx_queue urq_rx_queue_inst (.core_clk, .reset_n, .cfg, .cfg_apply, .rx_char, .rx_char_valid,
        .tx_busy, .tx_done, .tx_byte, .tx_parity_bit, .carrier_detect, .clear_to_send, .rd_en,
        .rd_entry, .rd_valid, .rx_irq, .carrier_event, .cts_event, .status);
    urq_remote_dev urq_remote_dev_inst (.core_clk, .reset_n, .send, .byte_in, .fault, .parity(cfg.parity),
        .rx_char, .rx_char_valid);
    // Clock
    always #50 core_clk = ~core_clk;
    // Pulse counters
    always @(posedge core_clk)
    begin
        irq_n += rx_irq;
        ev_n += carrier_event + cts_event;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #5;
    endtask : tick
    // Send n equal characters, then idle three cycles
    task automatic put(input logic [7:0] b, input logic [3:0] f, input int n);
        byte_in = b;
        fault = f;
        send = 1'b1;
        tick(n);
        send = 1'b0;
        tick(3);
    endtask : put
    task automatic apply;
        cfg_apply = 1'b1;
        tick(1);
        cfg_apply = 1'b0;
    endtask : apply
    task automatic final_report;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    // Hang guard
    initial
    begin
        #2000000;
        fail_count++;
        final_report();
    end
    // Main sequence
    initial
    begin
        tick(20);
        reset_n = 1'b1;
        tick(1);
        chk("reset", status != '0, 0);
        chk("empty", rd_valid, 0);
        foreach (rows[i])
        begin
            cfg.parity = rows[i].p;
            tx_byte = rows[i].b;
            tick(1);
            chk("parity", tx_parity_bit, rows[i].e);
        end
        cfg = '{10'h003, URQ_PAR_EVEN, 1'b1, 1'b1, 1'b1, 1'b1};
        apply();
        tick(2500);
        irq_n = 0;
        put(8'h5a, 4'h0, 3);
        chk("irq", irq_n, 1);
        chk("data", rd_entry.data, 8'h5a);
        chk("stamp", rd_entry.stamp inside {16'h0002, 16'h0003}, 1);
        chk("ready", rd_valid, 1);
        for (int i = 0; i < 4; i++)
            put(8'h11, 4'(1 << i), 1);
        chk("frame", status.frame_fault_count, 1);
        chk("parity", status.parity_fault_count, 1);
        chk("break", status.break_count, 1);
        chk("fifo", status.fifo_overrun_count, 1);
        chk("sum", status.any_error_count, 4);
        tx_busy = 1'b1;
        put(8'h22, 4'h0, 2);
        chk("drop", status.queue_fill_level, 7);
        tx_busy = 1'b0;
        tx_done = 1'b1;
        rd_en = 1'b1;
        tick(1);
        tx_done = 1'b0;
        tick(2);
        rd_en = 1'b0;
        tick(2);
        chk("pop", status.queue_fill_level, 4);
        chk("entry", {rd_entry.data, rd_entry.err_code}, 12'h111);
        ev_n = 0;
        carrier_detect = 1'b1;
        tick(3);
        clear_to_send = 1'b1;
        tick(3);
        carrier_detect = 1'b0;
        tick(3);
        chk("events", ev_n, 3);
        cfg.annotated_mode = 1'b0;
        cfg.parity = URQ_PAR_NONE;
        apply();
        tick(1);
        chk("restart", status != '0, 0);
        put(8'hc3, 4'h3, 1);
        chk("plain", {rd_entry.err_code, rd_entry.stamp}, 0);
        chk("plain data", rd_entry.data, 8'hc3);
        chk("frame", status.frame_fault_count, 1);
        chk("no parity", status.parity_fault_count, 0);
        put(8'h77, 4'h0, 1024);
        chk("full", status.queue_fill_level, 11'h400);
        chk("overrun", status.queue_overrun_count, 1);
        final_report();
    end
endmodule : testbench
`default_nettype wire
